/* src/wwcm_defs.vh */
// Constants for the windowed watchdog and clock monitor
`ifndef WWCM_DEFS_VH
`define WWCM_DEFS_VH

// =====================================================================
// Service register field layout
`define WWCM_WIN_HI        7
`define WWCM_WIN_LO        6
`define WWCM_KEY_HI        5
`define WWCM_KEY_LO        1
`define WWCM_CME_BIT       0
`define WWCM_KEY_VALUE     5'h0c
`define WWCM_SVC_RESET     8'hc1

// =====================================================================
// Window limits in idle-timer clocks
`define WWCM_LOWER_LIMIT   17'h00800
`define WWCM_UPPER_8K      17'h02000
`define WWCM_UPPER_16K     17'h04000
`define WWCM_UPPER_32K     17'h08000
`define WWCM_UPPER_64K     17'h10000

// =====================================================================
// Error output hold after the pin falls (16 to 32 cycles, 24 chosen)
`define WWCM_HOLD_CYCLES   6'h18
`define WWCM_HOLD_MAX      6'h20

// Clock monitor: reference clocks without an instruction tick before rejection
`define WWCM_CLKMON_LIMIT  16'h2710

`endif

/* src/wwcm_idle_timer.v */
// Free running idle timer with selectable pending flag
`timescale 1ns/1ns

module wwcm_idle_timer #(
	parameter WIDTH = 17
) (
	input  wire             i_clk,
	input  wire             i_tick,
	input  wire [2:0]       i_sel,
	input  wire             i_pnd_clr,
	output reg  [WIDTH-1:0] o_count,
	output reg              o_pnd
);

	// =================================================================
	// Selected tap: bit 12..16 toggles every 4k..64k ticks
	function tap_of;
		input [WIDTH-1:0] cnt;
		input [2:0]       sel;
		begin
			case (sel)
				3'h0:    tap_of = cnt[12];
				3'h1:    tap_of = cnt[13];
				3'h2:    tap_of = cnt[14];
				3'h3:    tap_of = cnt[15];
				default: tap_of = cnt[16];
			endcase
		end
	endfunction

	wire [WIDTH-1:0] count_d = o_count + {{(WIDTH-1){1'b0}}, 1'b1};
	wire             toggle  = i_tick && (tap_of(count_d, i_sel) != tap_of(o_count, i_sel));

	initial o_count = {WIDTH{1'b0}};
	initial o_pnd   = 1'b0;

	// =================================================================
	// Counter has no reset so an external reset leaves it running
	always @(posedge i_clk) begin
		if (i_tick)
			o_count <= count_d;
		// Set wins over the software clear
		if (toggle)
			o_pnd <= 1'b1;
		else if (i_pnd_clr)
			o_pnd <= 1'b0;
	end

endmodule

/* src/wwcm_clock_monitor.v */
// Clock monitor: flags a missing instruction-cycle clock
`timescale 1ns/1ns

module wwcm_clock_monitor #(
	parameter LIMIT = 16'h2710
) (
	input  wire i_clk,
	input  wire i_srst,
	input  wire i_enable,
	input  wire i_inst_tick,
	output reg  o_err
);

	reg [15:0] gap_q;

	// =================================================================
	// Counts reference clocks since the last instruction tick
	always @(posedge i_clk) begin
		if (i_srst) begin
			gap_q <= 16'h0000;
			o_err <= 1'b0;
		end else if (!i_enable || i_inst_tick) begin
			gap_q <= 16'h0000;
			o_err <= 1'b0;
		end else if (gap_q >= LIMIT) begin
			// A stopped clock in halt lands here too
			o_err <= 1'b1;
		end else begin
			gap_q <= gap_q + 16'h0001;
		end
	end

endmodule

/* src/wwcm_top.v */
// Windowed watchdog with clock monitor, top level
`timescale 1ns/1ns
`include "wwcm_defs.vh"

module wwcm_top #(
	parameter TW = 17
) (
	input  wire       I_CLOCK,
	input  wire       I_SRST,
	input  wire       I_IDLE_TICK,
	input  wire       I_INST_TICK,
	input  wire       I_SVC_WR,
	input  wire [7:0] I_SVC_WDATA,
	input  wire       I_HALT,
	input  wire       I_IDLE,
	input  wire       I_BOOT_ENTER,
	input  wire       I_BOOT_RETURN,
	input  wire [2:0] I_PND_SEL,
	input  wire       I_PND_CLR,
	input  wire       I_ERR_PIN_IN,
	output reg        O_ERR_PIN_OUT,
	output reg        O_ERR_PIN_OE,
	output reg  [7:0] O_SVC_RDATA,
	output reg        O_PND,
	output reg        O_WDOG_ERR,
	output reg        O_CLKMON_ERR
);

	// =================================================================
	// Output phases
	localparam PH_RUN  = 2'h0;
	localparam PH_FALL = 2'h1;
	localparam PH_HOLD = 2'h2;
	localparam PH_RISE = 2'h3;

	reg  [1:0]    win_q;
	reg           cme_q;
	reg           first_q;
	reg           lower_en_q;
	reg  [TW-1:0] wcnt_q;
	reg  [1:0]    ph_q;
	reg  [5:0]    hold_q;
	reg           pin_s1_q;
	reg           pin_s2_q;
	reg           lp_q;
	reg           idle_q;
	wire [TW-1:0] itimer;
	wire          pnd;
	wire          cm_err;

	// =================================================================
	// Upper limit decode
	function [TW-1:0] upper_of;
		input [1:0] w;
		begin
			case (w)
				2'h0:    upper_of = `WWCM_UPPER_8K;
				2'h1:    upper_of = `WWCM_UPPER_16K;
				2'h2:    upper_of = `WWCM_UPPER_32K;
				default: upper_of = `WWCM_UPPER_64K;
			endcase
		end
	endfunction

	wwcm_idle_timer #(
		.WIDTH    (TW)
	) u_timer (
		.i_clk    (I_CLOCK),
		.i_tick   (I_IDLE_TICK),
		.i_sel    (I_PND_SEL),
		.i_pnd_clr(I_PND_CLR),
		.o_count  (itimer),
		.o_pnd    (pnd)
	);

	wwcm_clock_monitor #(
		.LIMIT      (`WWCM_CLKMON_LIMIT)
	) u_clkmon (
		.i_clk      (I_CLOCK),
		.i_srst     (I_SRST),
		.i_enable   (cme_q),
		.i_inst_tick(I_INST_TICK),
		.o_err      (cm_err)
	);

	// =================================================================
	// Write decode
	wire       lowpower = I_HALT || I_IDLE;
	wire       key_ok   = I_SVC_WDATA[`WWCM_KEY_HI:`WWCM_KEY_LO] == `WWCM_KEY_VALUE;
	wire       all_ok   = key_ok
		&& (I_SVC_WDATA[`WWCM_WIN_HI:`WWCM_WIN_LO] == win_q)
		&& (I_SVC_WDATA[`WWCM_CME_BIT] == cme_q);
	wire       active   = (ph_q != PH_RUN);
	wire       wr       = I_SVC_WR && !active;
	wire       early    = lower_en_q && !first_q && (wcnt_q < `WWCM_LOWER_LIMIT);
	wire       late     = (wcnt_q >= upper_of(win_q));
	wire       bad_wr   = wr && (first_q ? !key_ok : (!all_ok || early));
	wire       good_wr  = wr && !bad_wr;
	wire       trip     = !lowpower && (bad_wr || (I_IDLE_TICK && late));
	wire       lp_exit  = lp_q && !lowpower;

	// =================================================================
	// Pin synchroniser, second stage only is read
	always @(posedge I_CLOCK) begin
		pin_s1_q <= I_ERR_PIN_IN;
		pin_s2_q <= pin_s1_q;
	end

	// =================================================================
	// Window, settings and output sequencing
	always @(posedge I_CLOCK) begin
		if (I_SRST) begin
			win_q      <= 2'h3;
			cme_q      <= 1'b1;
			first_q    <= 1'b1;
			lower_en_q <= 1'b1;
			wcnt_q     <= {TW{1'b0}};
			ph_q       <= PH_RUN;
			hold_q     <= 6'h00;
			lp_q       <= 1'b0;
			idle_q     <= 1'b0;
		end else begin
			lp_q   <= lowpower;
			idle_q <= I_IDLE;
			case (ph_q)
				PH_RUN: begin
					if (trip) begin
						ph_q <= PH_FALL;
					end else if (lp_exit) begin
						// Halt or idle exit restarts the window
						wcnt_q <= {TW{1'b0}};
					end else if (I_BOOT_ENTER) begin
						lower_en_q <= 1'b0;
						wcnt_q     <= {TW{1'b0}};
					end else if (I_BOOT_RETURN) begin
						lower_en_q <= 1'b1;
						wcnt_q     <= {TW{1'b0}};
					end else if (good_wr) begin
						if (first_q) begin
							win_q <= I_SVC_WDATA[`WWCM_WIN_HI:`WWCM_WIN_LO];
							cme_q <= I_SVC_WDATA[`WWCM_CME_BIT];
						end
						first_q <= 1'b0;
						wcnt_q  <= {TW{1'b0}};
					end else if (I_IDLE_TICK && !lowpower) begin
						wcnt_q <= wcnt_q + {{(TW-1){1'b0}}, 1'b1};
					end
				end
				PH_FALL: begin
					hold_q <= 6'h00;
					if (!pin_s2_q)
						ph_q <= PH_HOLD;
				end
				PH_HOLD: begin
					// Extra hold after the pin is seen low
					hold_q <= hold_q + 6'h01;
					if (hold_q == `WWCM_HOLD_CYCLES - 6'h01)
						ph_q <= PH_RISE;
				end
				PH_RISE: begin
					if (pin_s2_q) begin
						ph_q   <= PH_RUN;
						wcnt_q <= {TW{1'b0}};
					end
				end
				default: ph_q <= PH_RUN;
			endcase
		end
	end

	// =================================================================
	// Registered outputs; pin drive low is open drain
	always @(posedge I_CLOCK) begin
		if (I_SRST) begin
			O_ERR_PIN_OUT <= 1'b0;
			O_ERR_PIN_OE  <= 1'b0;
			O_SVC_RDATA   <= 8'h00;
			O_PND         <= 1'b0;
			O_WDOG_ERR    <= 1'b0;
			O_CLKMON_ERR  <= 1'b0;
		end else begin
			O_ERR_PIN_OUT <= 1'b0;
			O_ERR_PIN_OE  <= (ph_q == PH_FALL) || (ph_q == PH_HOLD) || cm_err;
			O_SVC_RDATA   <= {win_q, 5'h00, cme_q};
			O_PND         <= pnd;
			O_WDOG_ERR    <= active;
			O_CLKMON_ERR  <= cm_err;
		end
	end

endmodule

/* testbench/wwcm_sva.sv */
// Concurrent checks on the watchdog top level ports
`timescale 1ns/1ns
module wwcm_sva (
	input wire logic       I_CLOCK,
	input wire logic       I_SRST,
	input wire logic       I_SVC_WR,
	input wire logic [7:0] I_SVC_WDATA,
	input wire logic       I_HALT,
	input wire logic       I_IDLE,
	input wire logic       I_PND_CLR,
	input wire logic       I_ERR_PIN_IN,
	input wire logic       O_ERR_PIN_OUT,
	input wire logic       O_ERR_PIN_OE,
	input wire logic [7:0] O_SVC_RDATA,
	input wire logic       O_PND,
	input wire logic       O_WDOG_ERR,
	input wire logic       O_CLKMON_ERR
);
default clocking cb @(posedge I_CLOCK); endclocking
default disable iff (I_SRST);
// =====================================================================
// Error hold: pin seen low, then a bounded release
sequence s_drive; O_ERR_PIN_OE [*8]; endsequence
sequence s_release; ##[8:29] !O_ERR_PIN_OE; endsequence
AST_RST: assert property (disable iff (1'b0)
	I_SRST |=> !O_ERR_PIN_OE && !O_WDOG_ERR && !O_CLKMON_ERR) else $error("active in reset");
AST_RSTVAL: assert property ($fell(I_SRST) |-> ##[0:1] O_SVC_RDATA == 8'hc1)
	else $error("bad reset readback");
AST_KEYRD: assert property (O_SVC_RDATA[5:1] == 5'h00) else $error("key visible");
AST_BADSVC: assert property (
	I_SVC_WR && I_SVC_WDATA[5:1] != 5'h0c && !O_WDOG_ERR && !O_ERR_PIN_OE && !I_HALT && !I_IDLE
	|-> ##[1:2] O_ERR_PIN_OE) else $error("bad key not flagged");
AST_PINOUT: assert property (O_ERR_PIN_OE |-> O_ERR_PIN_OUT == 1'b0) else $error("pin high");
AST_CMON: assert property (O_CLKMON_ERR |-> ##[0:2] O_ERR_PIN_OE) else $error("no pull");
AST_HOLD: assert property (
	$fell(I_ERR_PIN_IN) && O_ERR_PIN_OE && !O_CLKMON_ERR |-> s_drive ##1 s_release)
	else $error("bad hold length");
AST_HALT: assert property (I_HALT && $past(I_HALT, 2) && !O_WDOG_ERR |=> !O_WDOG_ERR)
	else $error("error in halt");
AST_PND: assert property (O_PND && !I_PND_CLR && !$past(I_PND_CLR) |=> O_PND)
	else $error("flag lost");
endmodule
bind wwcm_top wwcm_sva wwcm_sva_i (.*);

/* testbench/wwcm_pin_model.sv */
// Error pin with pull-up and a slow falling edge
`timescale 1ns/1ns
module wwcm_pin_model #(
	parameter FALL = 2
) (
	input  wire logic i_clk,
	input  wire logic i_oe,
	input  wire logic i_out,
	output logic      o_pin
);
int n = 0;
// Load capacitance delays the fall; released pin floats up at once
always @(posedge i_clk) n <= i_oe ? n + 1 : 0;
assign o_pin = (i_oe && n >= FALL) ? i_out : 1'b1;
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the windowed watchdog
`timescale 1ns/1ns
module testbench;
// =====================================================================
// Bench signals
logic       clk = 0, srst = 1, wr = 0, halt = 0, inst = 0, pclr = 0, look = 0, stall = 0;
logic       idle = 0, bret = 0;
logic [7:0] wd = 0;
logic [2:0] psel = 0;
logic [9:0] q[$];
wire        pin, oe, pout, pnd, werr, cerr;
wire  [7:0] rd;
wire  [2:0] ev = {pnd, cerr, oe};
int         err_total = 0, tests_run = 0, seed = 44146, n;
// Clock and random instruction ticks, stopped to fake a dead clock
always #5 clk = ~clk;
always @(negedge clk) inst <= !stall && $random(seed) % 2 != 0;
wwcm_top wwcm_top_i (.I_CLOCK(clk), .I_SRST(srst), .I_IDLE_TICK(1'b1), .I_INST_TICK(inst),
	.I_SVC_WR(wr), .I_SVC_WDATA(wd), .I_HALT(halt), .I_IDLE(idle), .I_BOOT_ENTER(1'b0),
	.I_BOOT_RETURN(bret), .I_PND_SEL(psel), .I_PND_CLR(pclr), .I_ERR_PIN_IN(pin),
	.O_ERR_PIN_OUT(pout), .O_ERR_PIN_OE(oe), .O_SVC_RDATA(rd), .O_PND(pnd),
	.O_WDOG_ERR(werr), .O_CLKMON_ERR(cerr));
wwcm_pin_model wwcm_pin_model_i (.i_clk(clk), .i_oe(oe), .i_out(pout), .o_pin(pin));
// =====================================================================
// Checking and closing
task chk(logic [9:0] s, logic [9:0] e);
	tests_run++;
	if (s !== e) begin
		err_total++;
		$display("MISMATCH %0t seen %h expected %h", $time, s, e);
	end
endtask
task end_of_test;
	$display("mismatches %0d of %0d checks", err_total, tests_run);
	if (err_total == 0 && tests_run > 0)
		$display("TEST PASSED");
	else
		$display("TEST FAILED");
	$finish;
endtask
// Monitor takes the oldest note when the driver flags a result
always @(posedge clk) if (look) chk({werr, cerr, rd}, q.pop_front());
task note(logic [9:0] e);
	q.push_back(e);
	look = 1;
	@(negedge clk) look = 0;
endtask
task cyc(int c);
	repeat (c) @(negedge clk);
endtask
task svc(logic [7:0] d);
	wr = 1;
	wd = d;
	@(negedge clk) wr = 0;
endtask
// Bounded wait for an event line; too early or never is a mismatch
task wait_for(int s, logic lv, int lo, int hi);
	for (n = 0; ev[s] !== lv && n < hi; n++) @(negedge clk);
	chk({9'h0, n >= lo && n < hi}, 10'h1);
	if (n >= hi) end_of_test();
endtask
// =====================================================================
// Main sequence
initial begin
	cyc(2);
	srst = 0;
	cyc(1);
	note(10'h0c1);
	svc(8'h19);
	cyc(3);
	note(10'h001);
	svc(8'h19);
	wait_for(0, 1, 0, 5);
	svc(8'h00);
	wait_for(0, 0, 18, 40);
	cyc(8);
	note(10'h001);
	// Wrong window, then wrong monitor bit, then a clean service
	cyc(2100);
	svc(8'hd9);
	wait_for(0, 1, 0, 5);
	wait_for(0, 0, 18, 40);
	cyc(2100);
	svc(8'h18);
	wait_for(0, 1, 0, 5);
	wait_for(0, 0, 18, 40);
	cyc(2100);
	svc(8'h19);
	cyc(3);
	note(10'h001);
	wait_for(0, 1, 8000, 8300);
	wait_for(0, 0, 18, 40);
	// Halt with a dead clock: monitor fires, watchdog stays quiet
	cyc(8);
	halt = 1;
	stall = 1;
	wait_for(1, 1, 9900, 10010);
	note(10'h101);
	halt = 0;
	stall = 0;
	wait_for(1, 0, 0, 10);
	wait_for(0, 0, 0, 60);
	cyc(2100);
	svc(8'h19);
	cyc(3);
	note(10'h001);
	// Idle exit restarts the window, so a service 1000 ticks later is early
	cyc(1500);
	idle = 1;
	cyc(20);
	idle = 0;
	cyc(1000);
	svc(8'h19);
	wait_for(0, 1, 0, 5);
	wait_for(0, 0, 18, 40);
	cyc(2100);
	svc(8'h19);
	cyc(3);
	note(10'h001);
	// Boot return services and arms the lower check again
	cyc(1500);
	bret = 1;
	cyc(1);
	bret = 0;
	cyc(1000);
	svc(8'h19);
	wait_for(0, 1, 0, 5);
	wait_for(0, 0, 18, 40);
	pclr = 1;
	cyc(1);
	pclr = 0;
	// Registered flag drops one edge after the clear
	cyc(1);
	wait_for(2, 1, 1, 4100);
	srst = 1;
	cyc(2);
	note(10'h000);
	srst = 0;
	cyc(1);
	wait_for(2, 1, 0, 1);
	svc(8'hc3);
	wait_for(0, 1, 0, 5);
	wait_for(0, 0, 18, 40);
	end_of_test();
end
endmodule
